// ---- logic/ias_consts.vh ----
// Constants for the imaging front-end multiplexer sequencer
`ifndef IAS_CONSTS_VH
`define IAS_CONSTS_VH

// Register indices; byte address is four times the index
`define IAS_IDX_CONFIG    3'h0
`define IAS_IDX_MUXCFG    3'h1
`define IAS_IDX_RED_GAIN  3'h2
`define IAS_IDX_GRN_GAIN  3'h3
`define IAS_IDX_BLU_GAIN  3'h4
`define IAS_IDX_RED_OFS   3'h5
`define IAS_IDX_GRN_OFS   3'h6
`define IAS_IDX_BLU_OFS   3'h7
`define IAS_IDX_STATUS    6'h08
`define IAS_NUM_REGS      6'h08

// Register widths
`define IAS_REG_W         9
`define IAS_DATA_W        16

// Reset values
`define IAS_RST_CONFIG    9'h0f8
`define IAS_RST_MUXCFG    9'h0c0
`define IAS_RST_OTHER     9'h000

// Configuration register fields
`define IAS_CFG_THREE_CH  5
`define IAS_CFG_CDS       4
`define IAS_CFG_PWRDN     2

// Multiplexer register fields
`define IAS_MUX_ORDER     7
`define IAS_MUX_RED       6
`define IAS_MUX_GREEN     5
`define IAS_MUX_BLUE      4

// Channel identifiers
`define IAS_CH_RED        2'h0
`define IAS_CH_GREEN      2'h1
`define IAS_CH_BLUE       2'h2

// Output latency in converter clock cycles
`define IAS_LATENCY       3

`endif

// ---- logic/ias_regfile.v ----
// Register storage for configuration, multiplexer, gain and offset words
`timescale 1ns/10ps
`include "ias_consts.vh"

module ias_regfile
(
   // Clock and reset
   input  wire                  clk,
   input  wire                  rst_n,
   // Write port
   input  wire                  wr_en,
   input  wire [2:0]            wr_idx,
   input  wire [`IAS_REG_W-1:0] wr_data,
   // Registered read port
   input  wire [2:0]            rd_idx,
   output reg  [`IAS_REG_W-1:0] rd_data_q,
   // Direct views that steer the sequencer
   output wire [`IAS_REG_W-1:0] config_word,
   output wire [`IAS_REG_W-1:0] mux_word
);

   reg [`IAS_REG_W-1:0] mem_q [0:7];

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_word
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               if (g == 0)
                  mem_q[g] <= `IAS_RST_CONFIG;
               else if (g == 1)
                  mem_q[g] <= `IAS_RST_MUXCFG;
               else
                  mem_q[g] <= `IAS_RST_OTHER;
            end
            else if (wr_en && (wr_idx == g))
               mem_q[g] <= wr_data;
         end
      end
   endgenerate

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data_q <= `IAS_RST_OTHER;
      else
         rd_data_q <= mem_q[rd_idx];
   end

   assign config_word = mem_q[`IAS_IDX_CONFIG];
   assign mux_word    = mem_q[`IAS_IDX_MUXCFG];

endmodule

// ---- logic/ias_seq.v ----
// Multiplexer sequencer and mode control for a three-channel imaging front end
`timescale 1ns/10ps
`include "ias_consts.vh"

module ias_seq
(
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // APB slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Sampling and converter clock pins
   input  wire        reference_sample_clock,
   input  wire        pixel_sample_clock,
   input  wire        converter_clock,
   // Digitised channel levels
   input  wire [15:0] red_level,
   input  wire [15:0] green_level,
   input  wire [15:0] blue_level,
   // Sequencer outputs
   output wire [2:0]  gain_stage_select,
   output wire        sample_strobe,
   output wire [15:0] conv_data,
   output wire [1:0]  conv_channel,
   output wire        conv_valid,
   output wire        clamp_enable,
   output wire        cds_active
);

   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_P0   = 4'b0010;
   localparam [3:0] S_P1   = 4'b0100;
   localparam [3:0] S_P2   = 4'b1000;

   // Address decode: bit 4 valid, bit 3 status, bits 2:0 index
   function [4:0] map_addr;
      input [7:0] a;
      begin
         if (a[1:0] != 2'h0)
            map_addr = 5'h00;
         else if (a[7:2] < `IAS_NUM_REGS)
            map_addr = {2'b10, a[4:2]};
         else if (a[7:2] == `IAS_IDX_STATUS)
            map_addr = 5'h18;
         else
            map_addr = 5'h00;
      end
   endfunction

   function [2:0] one_hot_ch;
      input [1:0] ch;
      begin
         if (ch == `IAS_CH_RED)
            one_hot_ch = 3'h4;
         else if (ch == `IAS_CH_GREEN)
            one_hot_ch = 3'h2;
         else
            one_hot_ch = 3'h1;
      end
   endfunction

   // Reset release
   reg rst_s1_q;
   reg rst_s2_q;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_i_n = rst_s2_q;

   // Pin synchronisers; third stage only for edge detection
   wire [50:0] pin_in = {reference_sample_clock, pixel_sample_clock,
                         converter_clock, red_level, green_level,
                         blue_level};
   reg  [50:0] pin_s1_q;
   reg  [50:0] pin_s2_q;
   reg  [2:0]  clk_s3_q;
   always @(posedge core_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         pin_s1_q <= 51'h0;
         pin_s2_q <= 51'h0;
         clk_s3_q <= 3'h0;
      end
      else
      begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         clk_s3_q <= pin_s2_q[50:48];
      end
   end

   wire ref_fall  = !pin_s2_q[50] &&  clk_s3_q[2];
   wire pix_rise  =  pin_s2_q[49] && !clk_s3_q[1];
   wire pix_fall  = !pin_s2_q[49] &&  clk_s3_q[1];
   wire conv_rise =  pin_s2_q[48] && !clk_s3_q[0];
   wire conv_fall = !pin_s2_q[48] &&  clk_s3_q[0];
   wire [15:0] lvl [0:2];
   assign lvl[0] = pin_s2_q[47:32];
   assign lvl[1] = pin_s2_q[31:16];
   assign lvl[2] = pin_s2_q[15:0];

   // APB slave: one wait cycle, then pready
   reg         pready_q;
   reg         pslverr_q;
   reg  [31:0] prdata_q;
   wire [4:0]  dec       = map_addr(paddr);
   wire        apb_done  = psel && penable && pready_q;
   wire        reg_wr    = apb_done && pwrite && dec[4] && !dec[3];
   wire [8:0]  rd_word;
   wire [8:0]  cfg_word;
   wire [8:0]  mux_word;
   reg  [3:0]  state_q;
   reg  [1:0]  count_q;
   reg         cds_q;

   ias_regfile u_regs
   (
      .clk         (core_clk),
      .rst_n       (rst_i_n),
      .wr_en       (reg_wr),
      .wr_idx      (dec[2:0]),
      .wr_data     (pwdata[8:0]),
      .rd_idx      (dec[2:0]),
      .rd_data_q   (rd_word),
      .config_word (cfg_word),
      .mux_word    (mux_word)
   );

   always @(posedge core_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end
      else
      begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !dec[4];
         if (psel && penable && !pready_q)
         begin
            if (dec[4] && dec[3])
               prdata_q <= {25'h0, cds_q, count_q, state_q};
            else if (dec[4])
               prdata_q <= {23'h0, rd_word};
            else
               prdata_q <= 32'h0;
         end
      end
   end

   // Channel order worked out from the live register contents
   wire       sel_r = mux_word[`IAS_MUX_RED];
   wire       sel_g = mux_word[`IAS_MUX_GREEN];
   wire       sel_b = mux_word[`IAS_MUX_BLUE];
   wire       ord   = mux_word[`IAS_MUX_ORDER];
   wire [1:0] nsel  = {1'b0, sel_r} + {1'b0, sel_g} + {1'b0, sel_b};
   // Three set bits with the mode bit clear is treated as three channels
   wire       three = cfg_word[`IAS_CFG_THREE_CH] || (nsel == 2'h3);
   wire [1:0] cnt   = three ? 2'h3 : nsel;
   wire [1:0] asc0  = three ? `IAS_CH_RED :
                      sel_r ? `IAS_CH_RED :
                      sel_g ? `IAS_CH_GREEN : `IAS_CH_BLUE;
   wire [1:0] asc1  = three ? `IAS_CH_GREEN :
                      sel_b ? `IAS_CH_BLUE : `IAS_CH_GREEN;
   wire [1:0] asc2  = `IAS_CH_BLUE;
   wire [1:0] new0  = ord ? asc0 :
                      (cnt == 2'h3) ? asc2 :
                      (cnt == 2'h2) ? asc1 : asc0;
   wire [1:0] new1  = (ord || (cnt == 2'h3)) ? asc1 : asc0;
   wire [1:0] new2  = ord ? asc2 : asc0;

   reg  [1:0] slot_q [0:2];
   reg  [2:0] active_q;

   // Settings latched at each pixel clock rise
   always @(posedge core_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         slot_q[0] <= `IAS_CH_RED;
         slot_q[1] <= `IAS_CH_GREEN;
         slot_q[2] <= `IAS_CH_BLUE;
         count_q   <= 2'h3;
         cds_q     <= 1'b1;
         active_q  <= 3'h7;
      end
      else if (pix_rise)
      begin
         slot_q[0] <= new0;
         slot_q[1] <= new1;
         slot_q[2] <= new2;
         count_q   <= cnt;
         cds_q     <= cfg_word[`IAS_CFG_CDS];
         active_q  <= three ? 3'h7 : {sel_b, sel_g, sel_r};
      end
   end

   // Sequencer; a pixel clock rise takes priority over a converter rise
   reg [3:0] state_d;
   always @*
   begin
      state_d = state_q;
      if (pix_rise)
         state_d = S_IDLE;
      else if (conv_rise)
      begin
         case (state_q)
            S_IDLE:  state_d = (count_q != 2'h0) ? S_P0 : S_IDLE;
            S_P0:    state_d = (count_q > 2'h1) ? S_P1 : S_P0;
            S_P1:    state_d = (count_q > 2'h2) ? S_P2 : S_P0;
            S_P2:    state_d = S_P0;
            default: state_d = S_IDLE;
         endcase
      end
   end

   reg [1:0] cur_ch;
   always @*
   begin
      cur_ch = slot_q[0];
      if (state_q == S_P1)
         cur_ch = slot_q[1];
      else if (state_q == S_P2)
         cur_ch = slot_q[2];
   end

   reg [2:0] sel_q;
   always @(posedge core_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         state_q <= S_IDLE;
         sel_q   <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         sel_q   <= 3'h0;
         if (state_d == S_P0)
            sel_q <= one_hot_ch(slot_q[0]);
         else if (state_d == S_P1)
            sel_q <= one_hot_ch(slot_q[1]);
         else if (state_d == S_P2)
            sel_q <= one_hot_ch(slot_q[2]);
      end
   end

   // Per-channel sample and hold; sample-hold takes zero as reference
   reg [15:0] ref_q  [0:2];
   reg [15:0] held_q [0:2];
   genvar c;
   generate
      for (c = 0; c < 3; c = c + 1)
      begin : g_chan
         always @(posedge core_clk or negedge rst_i_n)
         begin
            if (!rst_i_n)
            begin
               ref_q[c]  <= 16'h0;
               held_q[c] <= 16'h0;
            end
            else
            begin
               if (ref_fall && cds_q && active_q[c])
                  ref_q[c] <= lvl[c];
               if (pix_fall && active_q[c])
                  held_q[c] <= cds_q ? lvl[c] - ref_q[c] : lvl[c];
            end
         end
      end
   endgenerate

   // Conversion pipeline stepped by converter falling edges
   reg [15:0] pipe_d_q [0:`IAS_LATENCY-1];
   reg [1:0]  pipe_c_q [0:`IAS_LATENCY-1];
   reg        pipe_v_q [0:`IAS_LATENCY-1];
   wire       take = conv_fall && (state_q != S_IDLE);
   generate
      for (c = 0; c < `IAS_LATENCY; c = c + 1)
      begin : g_pipe
         always @(posedge core_clk or negedge rst_i_n)
         begin
            if (!rst_i_n)
            begin
               pipe_d_q[c] <= 16'h0;
               pipe_c_q[c] <= 2'h0;
               pipe_v_q[c] <= 1'b0;
            end
            else if (conv_fall)
            begin
               if (c == 0)
               begin
                  pipe_d_q[c] <= held_q[cur_ch];
                  pipe_c_q[c] <= cur_ch;
                  pipe_v_q[c] <= take;
               end
               else
               begin
                  pipe_d_q[c] <= pipe_d_q[c-1];
                  pipe_c_q[c] <= pipe_c_q[c-1];
                  pipe_v_q[c] <= pipe_v_q[c-1];
               end
            end
         end
      end
   endgenerate

   reg [15:0] out_d_q;
   reg [1:0]  out_c_q;
   reg        out_v_q;
   reg        strobe_q;
   reg        clamp_q;
   always @(posedge core_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         out_d_q  <= 16'h0;
         out_c_q  <= 2'h0;
         out_v_q  <= 1'b0;
         strobe_q <= 1'b0;
         clamp_q  <= 1'b0;
      end
      else
      begin
         strobe_q <= take;
         // Follow the mode in the same cycle; the clamp lags it only for one cycle out of reset, as it resets low
         clamp_q  <= pix_rise ? cfg_word[`IAS_CFG_CDS] : cds_q;
         if (conv_fall)
         begin
            out_d_q <= pipe_d_q[`IAS_LATENCY-1];
            out_c_q <= pipe_c_q[`IAS_LATENCY-1];
            out_v_q <= pipe_v_q[`IAS_LATENCY-1];
         end
      end
   end

   assign prdata            = prdata_q;
   assign pready            = pready_q;
   assign pslverr           = pslverr_q;
   assign gain_stage_select = sel_q;
   assign sample_strobe     = strobe_q;
   assign conv_data         = out_d_q;
   assign conv_channel      = out_c_q;
   assign conv_valid        = out_v_q;
   assign clamp_enable      = clamp_q;
   assign cds_active        = cds_q;

endmodule

// ---- bench/ias_seq_asserts.sv ----
// Port checker for the multiplexer sequencer
`timescale 1ns/10ps
module ias_seq_chk
(
   // Clock and reset
   input wire        core_clk,
   input wire        rst_n,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Pins and outputs
   input wire        pixel_sample_clock,
   input wire        converter_clock,
   input wire [2:0]  gain_stage_select,
   input wire        sample_strobe,
   input wire        clamp_enable,
   input wire        cds_active
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   AST_PREADY_SLOT: assert property (psel && penable && !$past(penable)
      |=> pready) else $error("pready late");
   AST_PREADY_ONE: assert property (pready |=> !pready)
      else $error("pready held");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:9] == 23'h0)
      else $error("upper read bits set");
   AST_SEL_ONEHOT: assert property ($onehot0(gain_stage_select))
      else $error("select not one-hot");
   AST_CLAMP_SH: assert property (!cds_active |-> !clamp_enable)
      else $error("clamp on in sample-hold");
   AST_PIX_IDLE: assert property ($rose(pixel_sample_clock)
      |-> ##[3:5] gain_stage_select == 3'h0) else $error("no idle");
   AST_STROBE_FALL: assert property (sample_strobe
      |-> !converter_clock && !$past(converter_clock))
      else $error("strobe off falling edge");
   AST_STROBE_ONE: assert property (sample_strobe |=> !sample_strobe)
      else $error("strobe held");
endmodule

bind ias_seq ias_seq_chk i_chk (.core_clk, .rst_n, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .pixel_sample_clock,
   .converter_clock, .gain_stage_select, .sample_strobe, .clamp_enable,
   .cds_active);

// ---- bench/ias_tgen.sv ----
// Timing generator model for sampling clocks, converter clock and levels
`timescale 1ns/10ps
module ias_tgen
(
   // Clock
   input wire        core_clk,
   // Request
   input wire        go,
   input wire        correlated_double_sampling,
   input wire [3:0]  n_conv,
   input wire [47:0] pix,
   output reg        busy,
   // Pins
   output reg        ref_clk,
   output reg        pix_clk,
   output reg        conv_clk,
   output reg [47:0] lvl
);
   localparam [15:0] REF = 16'h0010;
   integer i;
   initial
   begin
      {busy, ref_clk, pix_clk, conv_clk} = 4'h0;
      lvl = 48'h0;
   end
   task tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   always
   begin
      @(posedge core_clk);
      if (go)
      begin
         busy <= 1'b1;
         lvl <= {3{REF}};
         ref_clk <= correlated_double_sampling;
         tick(4);
         ref_clk <= 1'b0;
         tick(4);
         lvl <= pix;
         pix_clk <= 1'b1;
         tick(4);
         pix_clk <= 1'b0;
         tick(2);
         // Released levels flip so a late capture shows up
         lvl <= ~pix;
         tick(2);
         for (i = 0; i < n_conv; i = i + 1)
         begin
            conv_clk <= 1'b1;
            tick(6);
            conv_clk <= 1'b0;
            tick(6);
         end
         busy <= 1'b0;
      end
   end
endmodule

// ---- bench/ias_seq_tb.sv ----
// Self-checking bench for the multiplexer sequencer
`timescale 1ns/10ps
module ias_seq_tb;
   localparam [15:0] REF = 16'h0010;
   localparam [47:0] PIX = {16'h9abc, 16'h5678, 16'h1234};
   reg         core_clk;
   reg         rst_n;
   reg  [7:0]  paddr;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        ref_clk;
   wire        pix_clk;
   wire        conv_clk;
   wire [47:0] lvl;
   wire [2:0]  gain_stage_select;
   wire        sample_strobe;
   wire [15:0] conv_data;
   wire [1:0]  conv_channel;
   wire        conv_valid;
   wire        clamp_enable;
   wire        cds_active;
   reg         go;
   reg         g_cds;
   reg  [3:0]  g_n;
   wire        busy;
   reg         sd;
   logic [2:0] gq[$];
   logic [17:0] cq[$];
   integer     failures;
   integer     samples_checked;

   ias_seq i_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reference_sample_clock(ref_clk), .pixel_sample_clock(pix_clk),
      .converter_clock(conv_clk), .red_level(lvl[15:0]),
      .green_level(lvl[31:16]), .blue_level(lvl[47:32]),
      .gain_stage_select(gain_stage_select), .sample_strobe(sample_strobe),
      .conv_data(conv_data), .conv_channel(conv_channel),
      .conv_valid(conv_valid), .clamp_enable(clamp_enable),
      .cds_active(cds_active));
   ias_tgen i_gen (.core_clk(core_clk), .go(go), .correlated_double_sampling(g_cds), .n_conv(g_n),
      .pix(PIX), .busy(busy), .ref_clk(ref_clk), .pix_clk(pix_clk),
      .conv_clk(conv_clk), .lvl(lvl));

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Output stands until the next fall, so one cycle late is safe
   always @(posedge core_clk)
   begin
      sd <= sample_strobe;
      if (sample_strobe === 1'b1)
         gq.push_back(gain_stage_select);
      if (sd === 1'b1 && conv_valid === 1'b1)
         cq.push_back({conv_channel, conv_data});
   end

   task chk(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp)
         begin
            failures = failures + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   task print_verdict;
      begin
         $display("checks %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r,
      output e);
      integer n;
      begin
         n = 0;
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge core_clk);
         penable <= 1'b1;
         do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
         if (pready !== 1'b1)
            failures = failures + 1;
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk);
      end
   endtask

   task pixel(input c, input [3:0] n);
      integer w;
      begin
         w = 0;
         g_cds <= c;
         g_n <= n;
         go <= 1'b1;
         do @(posedge core_clk); while (busy !== 1'b1);
         go <= 1'b0;
         do @(posedge core_clk); while (busy !== 1'b0 && ++w < 500);
         if (busy !== 1'b0)
            failures = failures + 1;
         repeat (8) @(posedge core_clk);
      end
   endtask

   task t_regs;
      reg [31:0] r;
      reg [31:0] s;
      reg        e;
      begin
         apb(0, 8'h00, 0, r, e);
         chk(r, 32'h0f8, "cfg_rst");
         apb(0, 8'h04, 0, r, e);
         chk(r, 32'h0c0, "mux_rst");
         apb(0, 8'h14, 0, r, e);
         chk(r, 0, "ofs_rst");
         apb(1, 8'h08, 32'h3f, r, e);
         apb(1, 8'h1c, 32'h1ff, r, e);
         apb(0, 8'h08, 0, r, e);
         chk(r, 32'h3f, "gain");
         apb(0, 8'h1c, 0, r, e);
         chk(r, 32'h1ff, "offset");
         apb(1, 8'h24, 32'h1, r, e);
         chk(e, 1, "unmapped");
         apb(0, 8'h02, 0, r, e);
         chk({r[30:0], e}, 1, "unalign");
         apb(0, 8'h20, 0, s, e);
         chk(s, 32'h71, "status");
         apb(1, 8'h20, 32'h1ff, r, e);
         chk(e, 0, "st_err");
         apb(0, 8'h20, 0, r, e);
         chk(r, s, "st_ro");
      end
   endtask

   // No channel selected outside three-channel mode: nothing converts
   task t_none;
      reg [31:0] r;
      reg        e;
      begin
         apb(1, 8'h00, 32'h0d8, r, e);
         apb(1, 8'h04, 32'h080, r, e);
         gq.delete();
         pixel(1, 4);
         chk(gq.size(), 0, "nosel");
         chk(conv_valid, 0, "noval");
         chk(gain_stage_select, 0, "noselect");
         apb(0, 8'h20, 0, r, e);
         chk(r, 32'h41, "status");
      end
   endtask

   task run_mode(input [8:0] cfg, input [8:0] mux, input [5:0] ord,
      input [1:0] nch, input c);
      integer i;
      reg [31:0] r;
      reg        e;
      reg [1:0]  ch;
      reg [15:0] v;
      begin
         apb(1, 8'h00, cfg, r, e);
         apb(1, 8'h04, mux, r, e);
         gq.delete();
         cq.delete();
         pixel(c, nch + 4);
         chk(clamp_enable, c, "clamp");
         chk(cds_active, c, "cds");
         chk(gq.size(), nch + 4, "strobes");
         for (i = 0; i < nch + 4; i++)
         begin
            ch = ord >> (2 * (i % nch));
            chk(gq[i], 3'h4 >> ch, "select");
            if (i <= nch)
            begin
               v = PIX >> (16 * ch);
               if (c)
                  v = v - REF;
               chk(cq[i + 3], {ch, v}, "output");
            end
         end
      end
   endtask

   initial
   begin
      failures = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      {psel, penable, pwrite, go, g_cds} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      g_n = 4'h0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs;
      pixel(1, 3);
      run_mode(9'h0f8, 9'h0c0, 6'h24, 3, 1);
      run_mode(9'h0f8, 9'h040, 6'h06, 3, 1);
      run_mode(9'h0e8, 9'h080, 6'h24, 3, 0);
      run_mode(9'h0d8, 9'h0e0, 6'h04, 2, 1);
      run_mode(9'h0d8, 9'h050, 6'h02, 2, 1);
      run_mode(9'h0c8, 9'h0b0, 6'h09, 2, 0);
      run_mode(9'h0d8, 9'h0a0, 6'h01, 1, 1);
      run_mode(9'h0c8, 9'h010, 6'h02, 1, 0);
      t_none;
      print_verdict;
   end

   initial
   begin
      #500000;
      failures = failures + 1;
      print_verdict;
   end
endmodule
